// ==== hw/bcss_top.sv ====
// Sync data word selection and status set evaluation with AXI4-Lite registers
//
// Local design decisions: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ns
// Functional notes
// - Time-tag sync needs configuration enable bit
// - Option applies only to mode code 17
// - Otherwise send RAM word at pointer
// - Both set: send low 16 time base bits
// - Even-sync bit forces time-tag word LSB to zero
// - Write sent word back at pointer address
// - Unmasked message error bit raises status set
// - Masked message error bit is ignored
// - Any unmasked flag bit raises status set
// - Mask enabled: unmasked broadcast bit raises set
// - Mask disabled: broadcast mismatch raises set
// - RT address mismatch raises status set
// - Mask to status bit pairing table
module bcss_top
  import bcss_pkg::*;
(
  // Clock and reset
  input wire logic CLK_I,
  input wire logic ARST_N_I,
  // AXI4-Lite write channels
  input wire logic AXI_AWVALID_I,
  output logic AXI_AWREADY_O,
  input wire logic [11:0] AXI_AWADDR_I,
  input wire logic AXI_WVALID_I,
  output logic AXI_WREADY_O,
  input wire logic [31:0] AXI_WDATA_I,
  input wire logic [3:0] AXI_WSTRB_I,
  output logic AXI_BVALID_O,
  input wire logic AXI_BREADY_I,
  output logic [1:0] AXI_BRESP_O,
  // AXI4-Lite read channels
  input wire logic AXI_ARVALID_I,
  output logic AXI_ARREADY_O,
  input wire logic [11:0] AXI_ARADDR_I,
  output logic AXI_RVALID_O,
  input wire logic AXI_RREADY_I,
  output logic [31:0] AXI_RDATA_O,
  output logic [1:0] AXI_RRESP_O,
  // Received RT status word, already validated
  input wire logic RT_STATUS_VALID_I,
  input wire logic [15:0] RT_STATUS_I,
  // Message result
  output logic STATUS_EVAL_O,
  output logic STATUS_SET_O,
  output logic SYNC_VALID_O,
  output logic [15:0] SYNC_WORD_O,
  // Interrupt
  output logic IRQ_O
);

  bcss_state_s s;
  bcss_state_s n;
  logic ram_en;
  logic ram_we;
  logic [7:0] ram_addr;
  logic [15:0] ram_wdata;
  logic [15:0] ram_rdata;
  logic [1:0] set_ev;
  logic [1:0] clr;
  logic [15:0] word;

  function automatic logic is_ram(input logic [11:0] a);
    return a[11:10] == RAM_SEL;
  endfunction

  function automatic logic is_sync_mc(input logic [15:0] c);
    return (c[9:5] == SA_MODE_LO || c[9:5] == SA_MODE_HI) && c[4:0] == MC_SYNC_DATA;
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] strb);
    return {strb[1] ? d[15:8] : old[15:8], strb[0] ? d[7:0] : old[7:0]};
  endfunction

  function automatic logic [15:0] sync_data(input logic [15:0] cfg, input logic [15:0] cw,
                                            input logic [15:0] cmd, input logic [15:0] ram,
                                            input logic [31:0] tb);
    logic [15:0] w;
    w = ram;
    if (cw[CW_TTSYNC_BIT] && cfg[CFG_TTSYNC_BIT] && is_sync_mc(cmd)) begin
      w = tb[15:0];
      if (cfg[CFG_EVEN_BIT]) begin
        w[0] = 1'b0;
      end
    end
    return w;
  endfunction

  function automatic logic status_set(input logic [15:0] cfg, input logic [15:0] cw,
                                      input logic [15:0] cmd, input logic [15:0] sw);
    logic hit;
    hit = !cw[CW_ME_MASK_BIT] && sw[SW_ME_BIT];
    hit = hit | (!cw[CW_SR_MASK_BIT] && sw[SW_SR_BIT]);
    hit = hit | (!cw[CW_BUSY_MASK_BIT] && sw[SW_BUSY_BIT]);
    hit = hit | (!cw[CW_SUBSYS_MASK_BIT] && sw[SW_SUBSYS_BIT]);
    hit = hit | (!cw[CW_TF_MASK_BIT] && sw[SW_TF_BIT]);
    hit = hit | (!cw[CW_RSV_MASK_BIT] && (|sw[SW_RSV_HI:SW_RSV_LO]));
    if (cfg[CFG_BCAST_EN_BIT]) begin
      hit = hit | (!cw[CW_BCR_MASK_BIT] && sw[SW_BCR_BIT]);
    end else begin
      hit = hit | (cw[CW_BCR_MASK_BIT] != sw[SW_BCR_BIT]);
    end
    hit = hit | (sw[ADDR_HI:ADDR_LO] != cmd[ADDR_HI:ADDR_LO]);
    return hit;
  endfunction

  function automatic logic [33:0] reg_read(input bcss_state_s st, input logic [11:0] a);
    logic [33:0] r;
    r = {RESP_OKAY, 32'h0000_0000};
    if (a == CTRL_ADDR) begin
      r[15:0] = st.ctrl;
    end else if (a == CMD_ADDR) begin
      r[15:0] = st.cmd;
    end else if (a == PTR_ADDR) begin
      r[15:0] = st.ptr;
    end else if (a == CFG_ADDR) begin
      r[15:0] = st.cfg;
    end else if (a == IRQ_STS_ADDR) begin
      r[1:0] = st.irq_sts;
    end else if (a == IRQ_EN_ADDR) begin
      r[1:0] = st.irq_en;
    end else if (a == SYNC_ADDR) begin
      r[15:0] = st.sync_word;
    end else if (a == RTSTS_ADDR) begin
      r[16:0] = {st.sset_last, st.last_sts};
    end else if (a == TB_LO_ADDR) begin
      r[31:0] = st.tbase;
    end else if (a == TB_HI_ADDR) begin
      r[15:0] = st.tbase[31:16];
    end else if (a == START_ADDR || a == IRQ_CLR_ADDR) begin
      r[31:0] = 32'h0000_0000;
    end else begin
      r[33:32] = RESP_SLVERR;
    end
    return r;
  endfunction

  bcss_ram u_ram (
    .clk_i(CLK_I),
    .en_i(ram_en),
    .we_i(ram_we),
    .addr_i(ram_addr),
    .wdata_i(ram_wdata),
    .rdata_o(ram_rdata)
  );

  always_comb begin
    n = s;
    ram_en = 1'b0;
    ram_we = 1'b0;
    ram_addr = 8'h00;
    ram_wdata = 16'h0000;
    set_ev = 2'b00;
    clr = 2'b00;
    word = 16'h0000;
    n.tbase = s.tbase + 32'h0000_0001;
    n.sync_valid = 1'b0;
    n.sset = 1'b0;
    n.seval = 1'b0;

    if (RT_STATUS_VALID_I) begin
      n.seval = 1'b1;
      n.sset = status_set(s.cfg, s.ctrl, s.cmd, RT_STATUS_I);
      n.sset_last = n.sset;
      n.last_sts = RT_STATUS_I;
      set_ev[IRQ_SSET_BIT] = n.sset;
    end

    // Sync message: fetch the data block word, then send and save it
    case (s.fsm)
      FSM_FETCH: begin
        ram_en = 1'b1;
        ram_addr = s.ptr[7:0];
        n.fsm = FSM_SEND;
      end
      FSM_SEND: begin
        word = sync_data(s.cfg, s.ctrl, s.cmd, ram_rdata, s.tbase);
        ram_en = 1'b1;
        ram_we = 1'b1;
        ram_addr = s.ptr[7:0];
        ram_wdata = word;
        n.sync_word = word;
        n.sync_valid = 1'b1;
        set_ev[IRQ_SYNC_BIT] = 1'b1;
        n.fsm = FSM_IDLE;
      end
      default: begin
      end
    endcase

    if (AXI_AWVALID_I && s.awready) begin
      n.awready = 1'b0;
      n.awaddr = AXI_AWADDR_I;
    end
    if (AXI_WVALID_I && s.wready) begin
      n.wready = 1'b0;
      n.wdata = AXI_WDATA_I;
      n.wstrb = AXI_WSTRB_I;
    end
    if (s.bvalid && AXI_BREADY_I) begin
      n.bvalid = 1'b0;
      n.awready = 1'b1;
      n.wready = 1'b1;
    end

    // Write commit once address and data are both held
    if (!s.awready && !s.wready && !s.bvalid) begin
      if (is_ram(s.awaddr)) begin
        // Memory is shared with the sync sequence, so software waits for it
        if (s.fsm == FSM_IDLE) begin
          ram_en = s.wstrb[1:0] == 2'b11;
          ram_we = s.wstrb[1:0] == 2'b11;
          ram_addr = s.awaddr[9:2];
          ram_wdata = s.wdata[15:0];
          n.bvalid = 1'b1;
          n.bresp = RESP_OKAY;
        end
      end else begin
        n.bvalid = 1'b1;
        n.bresp = RESP_OKAY;
        if (s.awaddr == CTRL_ADDR) begin
          n.ctrl = merge16(s.ctrl, s.wdata, s.wstrb);
        end else if (s.awaddr == CMD_ADDR) begin
          n.cmd = merge16(s.cmd, s.wdata, s.wstrb);
        end else if (s.awaddr == PTR_ADDR) begin
          n.ptr = merge16(s.ptr, s.wdata, s.wstrb);
        end else if (s.awaddr == CFG_ADDR) begin
          n.cfg = merge16(s.cfg, s.wdata, s.wstrb);
        end else if (s.awaddr == IRQ_EN_ADDR) begin
          n.irq_en = s.wstrb[0] ? s.wdata[1:0] : s.irq_en;
        end else if (s.awaddr == IRQ_CLR_ADDR) begin
          clr = s.wstrb[0] ? s.wdata[1:0] : 2'b00;
        end else if (s.awaddr == START_ADDR) begin
          // A start while a sequence runs is dropped
          if (s.wstrb[0] && s.wdata[0] && s.fsm == FSM_IDLE) begin
            n.fsm = FSM_FETCH;
          end
        end else if (reg_read(s, s.awaddr) == {RESP_SLVERR, 32'h0000_0000}) begin
          n.bresp = RESP_SLVERR;
        end
      end
    end

    if (AXI_ARVALID_I && s.arready) begin
      n.arready = 1'b0;
      n.araddr = AXI_ARADDR_I;
    end
    if (s.rvalid && AXI_RREADY_I) begin
      n.rvalid = 1'b0;
      n.arready = 1'b1;
    end
    if (!s.arready && !s.rvalid) begin
      if (is_ram(s.araddr)) begin
        if (s.rd_wait) begin
          n.rd_wait = 1'b0;
          n.rvalid = 1'b1;
          n.rresp = RESP_OKAY;
          n.rdata = {16'h0000, ram_rdata};
        end else if (s.fsm == FSM_IDLE && !ram_en) begin
          ram_en = 1'b1;
          ram_addr = s.araddr[9:2];
          n.rd_wait = 1'b1;
        end
      end else begin
        n.rvalid = 1'b1;
        {n.rresp, n.rdata} = reg_read(s, s.araddr);
      end
    end

    // Set wins over a clear in the same cycle
    n.irq_sts = (s.irq_sts & ~clr) | set_ev;
    n.irq = |(n.irq_sts & n.irq_en);
  end

  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      s <= BCSS_RST;
    end else begin
      s <= n;
    end
  end

  assign AXI_AWREADY_O = s.awready;
  assign AXI_WREADY_O = s.wready;
  assign AXI_BVALID_O = s.bvalid;
  assign AXI_BRESP_O = s.bresp;
  assign AXI_ARREADY_O = s.arready;
  assign AXI_RVALID_O = s.rvalid;
  assign AXI_RDATA_O = s.rdata;
  assign AXI_RRESP_O = s.rresp;
  assign STATUS_EVAL_O = s.seval;
  assign STATUS_SET_O = s.sset;
  assign SYNC_VALID_O = s.sync_valid;
  assign SYNC_WORD_O = s.sync_word;
  assign IRQ_O = s.irq;

  tt_gate_a: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
    (s.fsm == FSM_SEND && !s.cfg[CFG_TTSYNC_BIT]) |=> SYNC_WORD_O == $past(ram_rdata))
    else $error("sync word not from RAM while enable is clear");

  mc17_only_a: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
    (s.fsm == FSM_SEND && !is_sync_mc(s.cmd)) |=> SYNC_WORD_O == $past(ram_rdata))
    else $error("time tag used for a non sync command");

  sync_ram_a: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
    (s.fsm == FSM_SEND && !s.ctrl[CW_TTSYNC_BIT]) |=> SYNC_WORD_O == $past(ram_rdata))
    else $error("sync word not from RAM while option is clear");

  sync_tb_a: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
    (s.fsm == FSM_SEND && s.ctrl[CW_TTSYNC_BIT] && s.cfg[CFG_TTSYNC_BIT] && is_sync_mc(s.cmd)
     && !s.cfg[CFG_EVEN_BIT]) |=> SYNC_WORD_O == $past(s.tbase[15:0]))
    else $error("sync word differs from time base");

  even_lsb_a: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
    (s.fsm == FSM_SEND && s.ctrl[CW_TTSYNC_BIT] && s.cfg[CFG_TTSYNC_BIT] && is_sync_mc(s.cmd)
     && s.cfg[CFG_EVEN_BIT]) |=> SYNC_WORD_O == {$past(s.tbase[15:1]), 1'b0})
    else $error("forced even sync word is wrong");

  save_back_a: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
    (s.fsm == FSM_FETCH) |=> (ram_en && ram_we && ram_addr == $past(s.ptr[7:0]))
    ##1 (SYNC_VALID_O && SYNC_WORD_O == $past(ram_wdata)))
    else $error("sent sync word not written back at pointer");

  me_flag_a: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
    (RT_STATUS_VALID_I && !s.ctrl[CW_ME_MASK_BIT] && RT_STATUS_I[SW_ME_BIT]) |=> STATUS_SET_O)
    else $error("message error bit did not raise status set");

  me_mask_a: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
    (RT_STATUS_VALID_I && s.ctrl[CW_ME_MASK_BIT] && s.cfg[CFG_BCAST_EN_BIT]
     && RT_STATUS_I == {s.cmd[ADDR_HI:ADDR_LO], 11'h400}) |=> !STATUS_SET_O)
    else $error("masked message error raised status set");

  flag_pair_a: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
    (RT_STATUS_VALID_I && ((!s.ctrl[CW_SR_MASK_BIT] && RT_STATUS_I[SW_SR_BIT])
     || (!s.ctrl[CW_RSV_MASK_BIT] && |RT_STATUS_I[SW_RSV_HI:SW_RSV_LO])
     || (!s.ctrl[CW_TF_MASK_BIT] && RT_STATUS_I[SW_TF_BIT]))) |=> STATUS_SET_O)
    else $error("unmasked status flag did not raise status set");

  bcast_mask_a: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
    (RT_STATUS_VALID_I && s.cfg[CFG_BCAST_EN_BIT] && !s.ctrl[CW_BCR_MASK_BIT]
     && RT_STATUS_I[SW_BCR_BIT]) |=> STATUS_SET_O)
    else $error("unmasked broadcast bit did not raise status set");

  bcast_exp_a: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
    (RT_STATUS_VALID_I && !s.cfg[CFG_BCAST_EN_BIT]
     && s.ctrl[CW_BCR_MASK_BIT] != RT_STATUS_I[SW_BCR_BIT]) |=> STATUS_SET_O)
    else $error("broadcast mismatch did not raise status set");

  addr_chk_a: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
    (RT_STATUS_VALID_I && RT_STATUS_I[ADDR_HI:ADDR_LO] != s.cmd[ADDR_HI:ADDR_LO])
    |=> STATUS_SET_O && STATUS_EVAL_O)
    else $error("address mismatch did not raise status set");

  eval_once_a: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
    STATUS_SET_O |-> STATUS_EVAL_O && $past(RT_STATUS_VALID_I))
    else $error("status set without a received status word");

endmodule

// ==== hw/bcss_pkg.sv ====
// Package for the bus-controller sync word and status set block
package bcss_pkg;

  // Register byte addresses (12-bit AXI4-Lite space)
  localparam logic [11:0] CTRL_ADDR = 12'h000;
  localparam logic [11:0] CMD_ADDR = 12'h004;
  localparam logic [11:0] PTR_ADDR = 12'h008;
  localparam logic [11:0] START_ADDR = 12'h00C;
  localparam logic [11:0] IRQ_STS_ADDR = 12'h010;
  localparam logic [11:0] IRQ_EN_ADDR = 12'h014;
  localparam logic [11:0] IRQ_CLR_ADDR = 12'h018;
  localparam logic [11:0] SYNC_ADDR = 12'h01C;
  localparam logic [11:0] RTSTS_ADDR = 12'h020;
  localparam logic [11:0] TB_LO_ADDR = 12'h024;
  localparam logic [11:0] TB_HI_ADDR = 12'h028;
  localparam logic [9:0] CFG_IDX = 10'h032;
  localparam logic [11:0] CFG_ADDR = {CFG_IDX, 2'b00};
  localparam logic [1:0] RAM_SEL = 2'h1;

  // Configuration register fields and reset
  localparam int CFG_BCAST_EN_BIT = 0;
  localparam int CFG_EVEN_BIT = 2;
  localparam int CFG_TTSYNC_BIT = 3;
  localparam logic [15:0] CFG_RST = 16'h0000;

  // Message control word fields and reset
  localparam int CW_TTSYNC_BIT = 15;
  localparam int CW_ME_MASK_BIT = 14;
  localparam int CW_SR_MASK_BIT = 13;
  localparam int CW_BUSY_MASK_BIT = 12;
  localparam int CW_SUBSYS_MASK_BIT = 11;
  localparam int CW_TF_MASK_BIT = 10;
  localparam int CW_RSV_MASK_BIT = 9;
  localparam int CW_BCR_MASK_BIT = 5;
  localparam logic [15:0] CW_RST = 16'h0000;

  // RT status word fields
  localparam int SW_ME_BIT = 10;
  localparam int SW_SR_BIT = 8;
  localparam int SW_RSV_HI = 7;
  localparam int SW_RSV_LO = 5;
  localparam int SW_BCR_BIT = 4;
  localparam int SW_BUSY_BIT = 3;
  localparam int SW_SUBSYS_BIT = 2;
  localparam int SW_TF_BIT = 0;
  localparam int ADDR_HI = 15;
  localparam int ADDR_LO = 11;

  // Command word mode fields
  localparam logic [4:0] SA_MODE_LO = 5'h00;
  localparam logic [4:0] SA_MODE_HI = 5'h1F;
  localparam logic [4:0] MC_SYNC_DATA = 5'h11;

  // Interrupt bits
  localparam int IRQ_SYNC_BIT = 0;
  localparam int IRQ_SSET_BIT = 1;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    FSM_IDLE = 2'b00,
    FSM_FETCH = 2'b01,
    FSM_SEND = 2'b10
  } bcss_fsm_e;

  typedef struct packed {
    bcss_fsm_e fsm;
    logic [15:0] cfg;
    logic [15:0] ctrl;
    logic [15:0] cmd;
    logic [15:0] ptr;
    logic [31:0] tbase;
    logic [1:0] irq_sts;
    logic [1:0] irq_en;
    logic irq;
    logic [15:0] sync_word;
    logic sync_valid;
    logic sset;
    logic seval;
    logic sset_last;
    logic [15:0] last_sts;
    logic awready;
    logic wready;
    logic [11:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic [11:0] araddr;
    logic rd_wait;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } bcss_state_s;

  localparam bcss_state_s BCSS_RST = '{fsm: FSM_IDLE, cfg: CFG_RST, ctrl: CW_RST,
    awready: 1'b1, wready: 1'b1, arready: 1'b1, default: '0};

endpackage

// ==== hw/bcss_ram.sv ====
// Message data block memory, 256 words of 16 bits, registered read
`timescale 1ns/1ns
module bcss_ram (
  // Clock
  input wire logic clk_i,
  // Access port
  input wire logic en_i,
  input wire logic we_i,
  input wire logic [7:0] addr_i,
  input wire logic [15:0] wdata_i,
  output logic [15:0] rdata_o
);
  logic [15:0] mem [0:255];

  // No reset so the array maps onto block memory
  always_ff @(posedge clk_i) begin
    if (en_i) begin
      if (we_i) begin
        mem[addr_i] <= wdata_i;
      end else begin
        rdata_o <= mem[addr_i];
      end
    end
  end
endmodule

// ==== tb/bcss_rt_model.sv ====
// Remote terminal model that returns validated status words
`timescale 1ns/1ns
module bcss_rt_model (
  // Clock
  input wire logic clk_i,
  // Status word towards the bus controller
  output logic valid_o,
  output logic [15:0] status_o
);
  initial begin
    valid_o = 1'b0;
    status_o = 16'h0000;
  end
  // One word per pulse; the word is scrambled after the pulse so that no stale value can match
  task automatic send(input logic [15:0] w);
    @(posedge clk_i);
    valid_o <= 1'b1;
    status_o <= w;
    @(posedge clk_i);
    valid_o <= 1'b0;
    status_o <= ~w;
  endtask
endmodule

// ==== tb/tb_bcss_top.sv ====
// Self-checking bench for the sync word and status set block
`timescale 1ns/1ns
module tb_bcss_top;
  import bcss_pkg::*;
  localparam logic [11:0] RAM_A = 12'h41C;
  logic clk, arst_n, awvalid, wvalid, bready, arvalid, rready;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic awready, wready, bvalid, arready, rvalid, rt_valid, st_eval, st_set, sync_valid, irq;
  logic [1:0] bresp, rresp, r;
  logic [15:0] rt_status, sync_word, cyc;
  int fail_count = 0;
  int n_compared = 0;
  int mbit [8] = '{14, 13, 12, 11, 10, 9, 9, 9};
  int sbit [8] = '{10, 8, 3, 2, 0, 5, 6, 7};

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Own copy of the time base, counting every clock from reset
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) cyc <= 16'h0000;
    else cyc <= cyc + 16'h0001;
  end

  bcss_top uut (.CLK_I(clk), .ARST_N_I(arst_n),
    .AXI_AWVALID_I(awvalid), .AXI_AWREADY_O(awready), .AXI_AWADDR_I(awaddr),
    .AXI_WVALID_I(wvalid), .AXI_WREADY_O(wready), .AXI_WDATA_I(wdata), .AXI_WSTRB_I(wstrb),
    .AXI_BVALID_O(bvalid), .AXI_BREADY_I(bready), .AXI_BRESP_O(bresp),
    .AXI_ARVALID_I(arvalid), .AXI_ARREADY_O(arready), .AXI_ARADDR_I(araddr),
    .AXI_RVALID_O(rvalid), .AXI_RREADY_I(rready), .AXI_RDATA_O(rdata), .AXI_RRESP_O(rresp),
    .RT_STATUS_VALID_I(rt_valid), .RT_STATUS_I(rt_status), .STATUS_EVAL_O(st_eval),
    .STATUS_SET_O(st_set), .SYNC_VALID_O(sync_valid), .SYNC_WORD_O(sync_word), .IRQ_O(irq));

  bcss_rt_model rt (.clk_i(clk), .valid_o(rt_valid), .status_o(rt_status));

  task test_done;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task tmo(input string name);
    fail_count++;
    $display("BAD %s expected answer seen timeout", name);
    test_done();
  endtask

  task axi_wr(input logic [11:0] a, input logic [31:0] dat, output logic [1:0] resp);
    int n;
    resp = 2'h3;
    @(posedge clk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= dat;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        resp = bresp;
        bready <= 1'b0;
        break;
      end
    end
    if (n == 50) tmo("write");
  endtask

  task axi_rd(input logic [11:0] a, output logic [31:0] dat, output logic [1:0] resp);
    int n;
    dat = '0;
    resp = 2'h3;
    @(posedge clk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        dat = rdata;
        resp = rresp;
        rready <= 1'b0;
        break;
      end
    end
    if (n == 50) tmo("read");
  endtask

  task wr(input logic [11:0] a, input logic [31:0] dat);
    logic [1:0] rs;
    axi_wr(a, dat, rs);
    chk("bresp", {30'h0, RESP_OKAY}, {30'h0, rs});
  endtask

  task rd_chk(input string name, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] v;
    logic [1:0] rs;
    axi_rd(a, v, rs);
    chk("rresp", {30'h0, RESP_OKAY}, {30'h0, rs});
    chk(name, exp, v);
  endtask

  task sync_case(input logic opt, input logic ten, input logic even, input logic [15:0] cmd,
                 input logic use_tb);
    logic [15:0] w, dlt;
    int n;
    wr(RAM_A, 32'h0000F0F1);
    wr(CTRL_ADDR, {16'h0000, opt, 15'h0000});
    wr(CFG_ADDR, {28'h0000000, ten, even, 2'b00});
    wr(CMD_ADDR, {16'h0000, cmd});
    wr(START_ADDR, 32'h00000001);
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (sync_valid === 1'b1) break;
    end
    if (n == 20) tmo("sync_valid");
    w = sync_word;
    // Time base was taken in the send cycle, one clock before the word shows
    dlt = cyc - 16'h0001;
    if (even) dlt[0] = 1'b0;
    if (use_tb) begin
      chk("sync_time", {16'h0000, dlt}, {16'h0000, w});
      if (even) chk("sync_lsb", 32'h0, {31'h0, w[0]});
    end else begin
      chk("sync_ram", 32'h0000F0F1, {16'h0000, w});
    end
    rd_chk("ram_back", RAM_A, {16'h0000, w});
  endtask

  task st_case(input logic [15:0] ctl, input logic bcen, input logic [15:0] sw, input logic exp);
    wr(CTRL_ADDR, {16'h0000, ctl});
    wr(CFG_ADDR, {31'h0, bcen});
    rt.send(sw);
    @(posedge clk);
    chk("status_eval", 32'h1, {31'h0, st_eval});
    chk("status_set", {31'h0, exp}, {31'h0, st_set});
    @(posedge clk);
    chk("eval_once", 32'h0, {31'h0, st_eval});
  endtask

  initial begin
    arst_n = 1'b0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h00000000;
    wstrb = 4'hF;
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    rd_chk("ctrl_rst", CTRL_ADDR, 32'h0);
    rd_chk("cfg_rst", CFG_ADDR, 32'h0);
    rd_chk("irq_sts_rst", IRQ_STS_ADDR, 32'h0);
    axi_rd(12'h300, d, r);
    chk("unmapped_resp", {30'h0, RESP_SLVERR}, {30'h0, r});
    chk("unmapped_data", 32'h0, d);
    wr(CTRL_ADDR, 32'h0000FFFF);
    rd_chk("ctrl_rw", CTRL_ADDR, 32'h0000FFFF);
    // Low byte strobe only: the upper byte must keep its value
    wstrb <= 4'h1;
    wr(CTRL_ADDR, 32'h00000000);
    wstrb <= 4'hF;
    rd_chk("ctrl_strb", CTRL_ADDR, 32'h0000FF00);
    wr(SYNC_ADDR, 32'h00001234);
    rd_chk("sync_ro", SYNC_ADDR, 32'h0);
    wr(PTR_ADDR, 32'h00000007);
    rd_chk("ptr_rw", PTR_ADDR, 32'h00000007);
    // Mode code 17 with subaddress 0 and 31, then commands that must not take the time base
    sync_case(1'b1, 1'b1, 1'b0, 16'h2811, 1'b1);
    sync_case(1'b1, 1'b1, 1'b1, 16'h2BF1, 1'b1);
    sync_case(1'b0, 1'b1, 1'b1, 16'h2811, 1'b0);
    sync_case(1'b1, 1'b0, 1'b1, 16'h2811, 1'b0);
    sync_case(1'b1, 1'b1, 1'b1, 16'h2812, 1'b0);
    sync_case(1'b1, 1'b1, 1'b1, 16'h28B1, 1'b0);
    wr(CMD_ADDR, 32'h00002800);
    rd_chk("cmd_rw", CMD_ADDR, 32'h00002800);
    st_case(16'h0000, 1'b1, 16'h2800, 1'b0);
    st_case(16'h0000, 1'b1, 16'h2C00, 1'b1);
    st_case(16'h4000, 1'b1, 16'h2C00, 1'b0);
    for (int i = 0; i < 8; i++) begin
      st_case(16'h7E20 & ~(16'h0001 << mbit[i]), 1'b1, 16'h2800 | (16'h0001 << sbit[i]), 1'b1);
      st_case(16'h7E20, 1'b1, 16'h2800 | (16'h0001 << sbit[i]), 1'b0);
    end
    st_case(16'h7E00, 1'b1, 16'h2810, 1'b1);
    st_case(16'h7E20, 1'b1, 16'h2810, 1'b0);
    st_case(16'h7E20, 1'b0, 16'h2800, 1'b1);
    st_case(16'h7E20, 1'b0, 16'h2810, 1'b0);
    st_case(16'h7E00, 1'b0, 16'h2800, 1'b0);
    st_case(16'h7E20, 1'b1, 16'h3020, 1'b1);
    rd_chk("rt_sts", RTSTS_ADDR, 32'h00013020);
    // Both events have fired by now; the interrupt is masked, raised and cleared
    rd_chk("irq_sts", IRQ_STS_ADDR, 32'h3);
    wr(IRQ_EN_ADDR, 32'h0);
    repeat (2) @(posedge clk);
    chk("irq_masked", 32'h0, {31'h0, irq});
    wr(IRQ_EN_ADDR, 32'h2);
    repeat (2) @(posedge clk);
    chk("irq_on", 32'h1, {31'h0, irq});
    wr(IRQ_CLR_ADDR, 32'h2);
    repeat (2) @(posedge clk);
    chk("irq_cleared", 32'h0, {31'h0, irq});
    rd_chk("irq_sts_left", IRQ_STS_ADDR, 32'h1);
    test_done();
  end
endmodule
